/* rtl/eqlt_pkg.sv */
package eqlt_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned STRB_W = 4;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MANUAL = 10'h044;
  localparam logic [IDX_W-1:0] IDX_FLOOR  = 10'h045;
  localparam logic [IDX_W-1:0] IDX_SEL_A  = 10'h052;
  localparam logic [IDX_W-1:0] IDX_ENABLE = 10'h056;
  localparam logic [IDX_W-1:0] IDX_SEL_B  = 10'h057;
  localparam logic [IDX_W-1:0] IDX_POWER  = 10'h063;
  localparam logic [IDX_W-1:0] IDX_TARGET = 10'h070;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h071;

  // reset values
  localparam logic [7:0] RST_MANUAL = 8'h60;
  localparam logic [7:0] RST_FLOOR  = 8'h88;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [3:0] FLOOR_DEF  = 4'h8;

  // field positions
  localparam int unsigned OVR_BIT  = 0;
  localparam int unsigned STG2_LO  = 1;
  localparam int unsigned STG2_HI  = 3;
  localparam int unsigned STG1_LO  = 5;
  localparam int unsigned STG1_HI  = 7;
  localparam int unsigned FLOOR_HI = 3;
  localparam int unsigned SRC_BIT  = 7;
  localparam int unsigned CODE_LO  = 1;
  localparam int unsigned CODE_HI  = 2;
  localparam int unsigned DRV_BIT  = 3;
  localparam int unsigned SLP_BIT  = 0;
  localparam int unsigned TGT_BIT  = 0;
  localparam int unsigned ST_MISM  = 0;
  localparam int unsigned ST_ACT   = 1;
  localparam int unsigned ST_PORT1 = 2;

  // loop-through source codes
  localparam logic [1:0] CODE_PORT0 = 2'h1;
  localparam logic [1:0] CODE_PORT1 = 2'h2;

  typedef struct packed {
    logic [5:0] manual_value;
    logic       override;
    logic [3:0] floor_port0;
    logic [3:0] floor_port1;
  } eqlt_eq_cfg_t;

  typedef struct packed {
    logic       source_bit;
    logic [1:0] source_code;
    logic       driver_on;
    logic       tx_sleep;
    logic       port_zero;
    logic       port_one;
    logic       drive_active;
    logic       mismatch;
  } eqlt_loop_cfg_t;

endpackage : eqlt_pkg

/* rtl/eqlt_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bits 3 to 1 of the override register hold the low three bits of the manual equalizer value.
// - Bits 7 to 5 of the override register hold the high three bits of the manual equalizer value.
// - Adaptation starts from a four-bit floor value that resets to eight.
// - With the second-port target set, floor register writes go to the second port's copy.
// - Bit 7 of select A routes input zero when 0 and input one when 1, reset 0.
// - Bits 2 to 1 of select B pick input zero with code 01 and input one with code 10.
// - The loop-through driver outputs only while enable bit 3 is set, reset disabled.
// - Bit 0 of the power register powers the loop-through transmitter down when set.
module eqlt_config_regs
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [eqlt_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [eqlt_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [eqlt_pkg::STRB_W-1:0]   pstrb,
  output var  logic [eqlt_pkg::DATA_W-1:0]   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // configuration out
  output var  eqlt_pkg::eqlt_eq_cfg_t        eq_cfg,
  output var  eqlt_pkg::eqlt_loop_cfg_t      loop_cfg
);

  logic [7:0]                  manual_ff;
  logic [7:0]                  floor0_ff;
  logic [7:0]                  floor1_ff;
  logic [7:0]                  sel_a_ff;
  logic [7:0]                  enable_ff;
  logic [7:0]                  sel_b_ff;
  logic [7:0]                  power_ff;
  logic [7:0]                  target_ff;
  logic [eqlt_pkg::DATA_W-1:0] prdata_ff;
  logic                        pslverr_ff;
  logic [eqlt_pkg::IDX_W-1:0]  idx;
  logic                        aligned;
  logic                        mapped;
  logic                        wr_en;
  logic [7:0]                  wbyte;
  logic [7:0]                  rd_byte;
  logic [7:0]                  status;
  logic                        port_zero;
  logic                        port_one;
  logic                        mismatch;
  logic                        drive_active;

  assign idx     = paddr[eqlt_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wbyte   = pwdata[7:0];

  always_comb
  begin
    case (idx)
      eqlt_pkg::IDX_MANUAL,
      eqlt_pkg::IDX_FLOOR,
      eqlt_pkg::IDX_SEL_A,
      eqlt_pkg::IDX_ENABLE,
      eqlt_pkg::IDX_SEL_B,
      eqlt_pkg::IDX_POWER,
      eqlt_pkg::IDX_TARGET,
      eqlt_pkg::IDX_STATUS: mapped = aligned;
      default:              mapped = 1'b0;
    endcase
  end

  // writes land at the access phase, low byte lane only
  assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;

  // manual equalizer value and bypass
  always_ff @(posedge clk)
  begin
    if (reset)
      manual_ff <= eqlt_pkg::RST_MANUAL;
    else if (wr_en && idx == eqlt_pkg::IDX_MANUAL)
      manual_ff <= wbyte;
  end

  // per-port floor copies, steered by the port target
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      floor0_ff <= eqlt_pkg::RST_FLOOR;
      floor1_ff <= eqlt_pkg::RST_FLOOR;
    end
    else if (wr_en && idx == eqlt_pkg::IDX_FLOOR)
    begin
      if (target_ff[eqlt_pkg::TGT_BIT])
        floor1_ff <= wbyte;
      else
        floor0_ff <= wbyte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      target_ff <= eqlt_pkg::RST_ZERO;
    else if (wr_en && idx == eqlt_pkg::IDX_TARGET)
      target_ff <= wbyte;
  end

  // loop-through source selects
  always_ff @(posedge clk)
  begin
    if (reset)
      sel_a_ff <= eqlt_pkg::RST_ZERO;
    else if (wr_en && idx == eqlt_pkg::IDX_SEL_A)
      sel_a_ff <= wbyte;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      sel_b_ff <= eqlt_pkg::RST_ZERO;
    else if (wr_en && idx == eqlt_pkg::IDX_SEL_B)
      sel_b_ff <= wbyte;
  end

  // driver enable and transmitter power-down
  always_ff @(posedge clk)
  begin
    if (reset)
      enable_ff <= eqlt_pkg::RST_ZERO;
    else if (wr_en && idx == eqlt_pkg::IDX_ENABLE)
      enable_ff <= wbyte;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      power_ff <= eqlt_pkg::RST_ZERO;
    else if (wr_en && idx == eqlt_pkg::IDX_POWER)
      power_ff <= wbyte;
  end

  // port decode; codes 00 and 11 select no port
  assign port_zero = (sel_b_ff[eqlt_pkg::CODE_HI:eqlt_pkg::CODE_LO] == eqlt_pkg::CODE_PORT0);
  assign port_one  = (sel_b_ff[eqlt_pkg::CODE_HI:eqlt_pkg::CODE_LO] == eqlt_pkg::CODE_PORT1);

  // both selects must agree on one valid port
  assign mismatch = !(port_zero || port_one) ||
                    (sel_a_ff[eqlt_pkg::SRC_BIT] != port_one);

  // driver live only when enabled, powered and pointed at a port
  assign drive_active = enable_ff[eqlt_pkg::DRV_BIT] &&
                        !power_ff[eqlt_pkg::SLP_BIT] &&
                        (port_zero || port_one);

  always_comb
  begin
    status                    = 8'h00;
    status[eqlt_pkg::ST_MISM]  = mismatch;
    status[eqlt_pkg::ST_ACT]   = drive_active;
    status[eqlt_pkg::ST_PORT1] = port_one;
  end

  always_comb
  begin
    case (idx)
      eqlt_pkg::IDX_MANUAL: rd_byte = manual_ff;
      eqlt_pkg::IDX_FLOOR:
      begin
        if (target_ff[eqlt_pkg::TGT_BIT])
          rd_byte = floor1_ff;
        else
          rd_byte = floor0_ff;
      end
      eqlt_pkg::IDX_SEL_A:  rd_byte = sel_a_ff;
      eqlt_pkg::IDX_ENABLE: rd_byte = enable_ff;
      eqlt_pkg::IDX_SEL_B:  rd_byte = sel_b_ff;
      eqlt_pkg::IDX_POWER:  rd_byte = power_ff;
      eqlt_pkg::IDX_TARGET: rd_byte = target_ff;
      eqlt_pkg::IDX_STATUS: rd_byte = status;
      default:              rd_byte = 8'h00;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_ff <= {24'h00_0000, (mapped ? rd_byte : 8'h00)};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pslverr_ff <= 1'b0;
    else if (psel && !penable)
      pslverr_ff <= !mapped;
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = pslverr_ff && psel && penable;

  always_comb
  begin
    eq_cfg.manual_value = {manual_ff[eqlt_pkg::STG1_HI:eqlt_pkg::STG1_LO],
                           manual_ff[eqlt_pkg::STG2_HI:eqlt_pkg::STG2_LO]};
    eq_cfg.override     = manual_ff[eqlt_pkg::OVR_BIT];
    eq_cfg.floor_port0  = floor0_ff[eqlt_pkg::FLOOR_HI:0];
    eq_cfg.floor_port1  = floor1_ff[eqlt_pkg::FLOOR_HI:0];
  end

  always_comb
  begin
    loop_cfg.source_bit   = sel_a_ff[eqlt_pkg::SRC_BIT];
    loop_cfg.source_code  = sel_b_ff[eqlt_pkg::CODE_HI:eqlt_pkg::CODE_LO];
    loop_cfg.driver_on    = enable_ff[eqlt_pkg::DRV_BIT];
    loop_cfg.tx_sleep     = power_ff[eqlt_pkg::SLP_BIT];
    loop_cfg.port_zero    = port_zero;
    loop_cfg.port_one     = port_one;
    loop_cfg.drive_active = drive_active;
    loop_cfg.mismatch     = mismatch;
  end

  // checks
  logic [7:0] wbyte_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      wbyte_q <= 8'h00;
    else
      wbyte_q <= wbyte;
  end

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (reset);

  sequence s_wr(logic [eqlt_pkg::IDX_W-1:0] at);
    psel && penable && pwrite && pstrb[0] && paddr == {at, 2'h0};
  endsequence

  property p_stage2_low;
    s_wr(eqlt_pkg::IDX_MANUAL) |=> eq_cfg.manual_value[2:0] == wbyte_q[3:1];
  endproperty
  a_stage2_low: assert property (p_stage2_low)
    else $error("manual value low bits not taken from write");

  property p_stage1_high;
    s_wr(eqlt_pkg::IDX_MANUAL) |=> eq_cfg.manual_value[5:3] == wbyte_q[7:5];
  endproperty
  a_stage1_high: assert property (p_stage1_high)
    else $error("manual value high bits not taken from write");

  property p_override;
    s_wr(eqlt_pkg::IDX_MANUAL) |=> eq_cfg.override == wbyte_q[0];
  endproperty
  a_override: assert property (p_override)
    else $error("bypass bit not taken from write");

  property p_floor_reset;
    $fell(reset) |-> eq_cfg.floor_port0 == eqlt_pkg::FLOOR_DEF &&
                     eq_cfg.floor_port1 == eqlt_pkg::FLOOR_DEF;
  endproperty
  a_floor_reset: assert property (p_floor_reset)
    else $error("floor not eight after reset");

  property p_floor_port1;
    s_wr(eqlt_pkg::IDX_FLOOR) and target_ff[eqlt_pkg::TGT_BIT]
      |=> eq_cfg.floor_port1 == wbyte_q[3:0] && $stable(eq_cfg.floor_port0);
  endproperty
  a_floor_port1: assert property (p_floor_port1)
    else $error("floor write missed second port");

  property p_src_bit;
    s_wr(eqlt_pkg::IDX_SEL_A) |=> loop_cfg.source_bit == wbyte_q[7];
  endproperty
  a_src_bit: assert property (p_src_bit)
    else $error("source bit not taken from write");

  property p_code;
    s_wr(eqlt_pkg::IDX_SEL_B) |=>
      loop_cfg.port_one == (wbyte_q[2:1] == eqlt_pkg::CODE_PORT1) &&
      loop_cfg.port_zero == (wbyte_q[2:1] == eqlt_pkg::CODE_PORT0);
  endproperty
  a_code: assert property (p_code)
    else $error("source code decode wrong");

  property p_drive;
    s_wr(eqlt_pkg::IDX_ENABLE) |=> loop_cfg.drive_active ==
      (wbyte_q[3] && !loop_cfg.tx_sleep && (port_zero || port_one));
  endproperty
  a_drive: assert property (p_drive)
    else $error("driver state does not follow enable");

  property p_sleep;
    s_wr(eqlt_pkg::IDX_POWER) |=> loop_cfg.tx_sleep == wbyte_q[0] &&
      (!wbyte_q[0] || !loop_cfg.drive_active);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("power-down not taken from write");

  property p_sleep_off;
    loop_cfg.tx_sleep |-> !loop_cfg.drive_active;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("driver live while powered down");

  property p_drive_off;
    !loop_cfg.driver_on |-> !loop_cfg.drive_active;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("driver live while disabled");

  property p_loop_reset;
    $fell(reset) |-> !loop_cfg.driver_on && !loop_cfg.tx_sleep &&
                     !loop_cfg.source_bit && !loop_cfg.drive_active;
  endproperty
  a_loop_reset: assert property (p_loop_reset)
    else $error("loop-through controls not idle after reset");

  property p_manual_reset;
    $fell(reset) |-> eq_cfg.manual_value == 6'h18 && !eq_cfg.override;
  endproperty
  a_manual_reset: assert property (p_manual_reset)
    else $error("manual value not at default after reset");

  // status is read-only, a write leaves every control alone
  property p_status_ro;
    s_wr(eqlt_pkg::IDX_STATUS) |=> $stable(loop_cfg) && $stable(eq_cfg);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write changed a control");

  // floor reads follow the same port steering as writes
  sequence s_rd(logic [eqlt_pkg::IDX_W-1:0] at);
    psel && !penable && !pwrite && paddr == {at, 2'h0};
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  property p_floor_read;
    s_rd(eqlt_pkg::IDX_FLOOR) ##1 s_access |->
      prdata[3:0] == (target_ff[eqlt_pkg::TGT_BIT] ?
                      eq_cfg.floor_port1 : eq_cfg.floor_port0);
  endproperty
  a_floor_read: assert property (p_floor_read)
    else $error("floor read not steered by port target");

endmodule : eqlt_config_regs

`default_nettype wire

/* tb/test_eqlt_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_eqlt_config_regs;
  typedef struct {
    logic [9:0] idx;
    logic [7:0] rst;
    logic [7:0] wd;
  } eqlt_row_t;

  logic                          clk;
  logic                          reset;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [eqlt_pkg::ADDR_W-1:0]   paddr;
  logic [eqlt_pkg::DATA_W-1:0]   pwdata;
  logic [eqlt_pkg::STRB_W-1:0]   pstrb;
  logic [eqlt_pkg::DATA_W-1:0]   prdata;
  logic                          pready;
  logic                          pslverr;
  eqlt_pkg::eqlt_eq_cfg_t        eq_cfg;
  eqlt_pkg::eqlt_loop_cfg_t      loop_cfg;
  logic [31:0]                   rdat;
  logic                          rerr;
  int                            errors;
  int                            compares;
  eqlt_row_t                     rows [6];

  eqlt_config_regs u_dut (
    .clk      (clk),
    .reset    (reset),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .eq_cfg   (eq_cfg),
    .loop_cfg (loop_cfg)
  );

  always #2 clk = ~clk;

  // one apb transfer, waits for pready, ends one edge after release
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     input logic [3:0] st, input logic [1:0] lo);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    pwdata  <= {24'h000000, wd};
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errors++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 4'hF, 2'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    apb(1'b0, idx, 8'h00, 4'h0, 2'h0);
  endtask : rd

  task automatic results;
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #20000;
    errors++;
    results();
  end

  initial
  begin
    clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; pstrb = 4'h0;
    errors = 0; compares = 0;
    rows[0] = '{eqlt_pkg::IDX_MANUAL, 8'h60, 8'hAB};
    rows[1] = '{eqlt_pkg::IDX_FLOOR, 8'h88, 8'h53};
    rows[2] = '{eqlt_pkg::IDX_SEL_A, 8'h00, 8'h80};
    rows[3] = '{eqlt_pkg::IDX_ENABLE, 8'h00, 8'h08};
    rows[4] = '{eqlt_pkg::IDX_SEL_B, 8'h00, 8'h04};
    rows[5] = '{eqlt_pkg::IDX_POWER, 8'h00, 8'hFE};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(eq_cfg.manual_value, 6'h18);
    `CHK({eq_cfg.override, eq_cfg.floor_port0, eq_cfg.floor_port1}, 9'h088);
    `CHK({loop_cfg.source_bit, loop_cfg.driver_on, loop_cfg.tx_sleep}, 3'h0);
    foreach (rows[i])
    begin
      rd(rows[i].idx);
      `CHK(rdat, {24'h000000, rows[i].rst});
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx);
      `CHK({rerr, rdat}, {9'h000, 16'h0000, rows[i].wd});
    end
    `CHK(eq_cfg.manual_value, 6'h2D);
    `CHK({eq_cfg.override, eq_cfg.floor_port0}, 5'h13);
    `CHK({loop_cfg.source_bit, loop_cfg.source_code, loop_cfg.port_one}, 4'hD);
    `CHK({loop_cfg.driver_on, loop_cfg.tx_sleep, loop_cfg.drive_active}, 3'h5);
    `CHK(loop_cfg.mismatch, 1'b0);
    rd(eqlt_pkg::IDX_STATUS);
    `CHK(rdat, 32'h00000006);
    // power-down wins over the enable
    wr(eqlt_pkg::IDX_POWER, 8'h01);
    `CHK({loop_cfg.tx_sleep, loop_cfg.drive_active}, 2'h2);
    wr(eqlt_pkg::IDX_POWER, 8'h00);
    wr(eqlt_pkg::IDX_ENABLE, 8'h00);
    `CHK({loop_cfg.driver_on, loop_cfg.drive_active}, 2'h0);
    // code 01 against source bit 1 disagrees
    wr(eqlt_pkg::IDX_SEL_B, 8'h02);
    `CHK({loop_cfg.port_zero, loop_cfg.port_one, loop_cfg.mismatch}, 3'h5);
    rd(eqlt_pkg::IDX_STATUS);
    `CHK(rdat, 32'h00000001);
    wr(eqlt_pkg::IDX_SEL_B, 8'h06);
    `CHK({loop_cfg.port_zero, loop_cfg.port_one, loop_cfg.mismatch}, 3'h1);
    wr(eqlt_pkg::IDX_MANUAL, 8'hAA);
    `CHK({eq_cfg.override, eq_cfg.manual_value}, 7'h2D);
    // second port floor copy
    wr(eqlt_pkg::IDX_TARGET, 8'h01);
    wr(eqlt_pkg::IDX_FLOOR, 8'h7C);
    `CHK({eq_cfg.floor_port0, eq_cfg.floor_port1}, 8'h3C);
    rd(eqlt_pkg::IDX_FLOOR);
    `CHK(rdat, 32'h0000007C);
    wr(eqlt_pkg::IDX_TARGET, 8'h00);
    rd(eqlt_pkg::IDX_FLOOR);
    `CHK(rdat, 32'h00000053);
    // refused and ignored accesses
    rd(10'h3FF);
    `CHK({rerr, rdat}, 33'h100000000);
    apb(1'b1, eqlt_pkg::IDX_FLOOR, 8'h11, 4'hF, 2'h2);
    `CHK(rerr, 1'b1);
    apb(1'b1, eqlt_pkg::IDX_FLOOR, 8'h11, 4'hE, 2'h0);
    `CHK({rerr, eq_cfg.floor_port0}, 5'h03);
    wr(eqlt_pkg::IDX_STATUS, 8'hFF);
    rd(eqlt_pkg::IDX_STATUS);
    `CHK({rerr, rdat}, 33'h000000001);
    // reset in mid-run restores the defaults
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK({eq_cfg.manual_value, eq_cfg.floor_port0, loop_cfg.source_bit}, 11'h310);
    results();
  end
endmodule : test_eqlt_config_regs

`default_nettype wire
